// File: dv/mls_chk.sv
// Bus and interrupt checker for the modem line status block
`timescale 1ns/1ps
module mls_chk (
   input wire logic        core_clk, rst, read, write, waitrequest, irq,
   input wire logic [15:0] address,
   input wire logic [31:0] readdata
);
default clocking @(posedge core_clk); endclocking
default disable iff rst;
a_wait_one: assert property ((read|write) && !$past(read|write) |-> waitrequest ##1 !waitrequest)
   else $error("first cycle of a request not held off");
a_wait_bound: assert property (waitrequest |=> !waitrequest)
   else $error("more than one wait cycle");
a_idle_nowait: assert property (!(read|write) |-> !waitrequest)
   else $error("wait without request");
a_high_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
   else $error("upper read bytes not zero");
a_unmap_zero: assert property (read && !waitrequest && !(address inside {16'hffa4, 16'hffa6, 16'hffb0})
   |-> readdata == 32'h0)
   else $error("unmapped read not zero");
a_data_hold: assert property (!read |=> $stable(readdata))
   else $error("read data moved without a read");
a_irq_clear: assert property ($fell(irq) |-> $past(write) || $past(write, 2))
   else $error("interrupt dropped without a write");
a_irq_reset: assert property ($fell(rst) |-> !irq)
   else $error("interrupt high after reset");
cover property (irq);
cover property (write && !waitrequest);
cover property (read && !waitrequest && readdata[2]);
endmodule
bind modem_line_status mls_chk u_chk (.core_clk, .rst, .read, .write, .waitrequest, .irq, .address, .readdata);

// File: dv/modem_model.sv
// Modem side model driving the active-low handshake pins
`timescale 1ns/1ps
module modem_model import msr_pkg::*; (
   input wire logic         core_clk,
   input wire modem_lines_t lvl,
   output modem_lines_t     modem_n = 4'hf
);
always @(posedge core_clk) modem_n <= ~lvl;
endmodule

// File: dv/tb_modem_line_status.sv
// Self-checking bench for the modem line status block
`timescale 1ns/1ps
module tb_modem_line_status;
import msr_pkg::*;
logic core_clk = 0, rst = 1, read = 0, write = 0, waitrequest, irq;
logic [15:0] address = 16'h0;
logic [31:0] writedata = 32'h0, readdata, rd;
modem_lines_t lvl = 4'h0, modem_n;
int mismatches = 0, n_checks = 0;
modem_line_status dut (.core_clk, .rst, .address, .read, .write, .writedata, .byteenable(4'h1), .readdata,
   .waitrequest, .modem_n, .irq);
modem_model peer (.core_clk, .lvl, .modem_n);
task finish_test;
   if (mismatches == 0 && n_checks > 0) $display("verification passed");
   else $display("verification failed");
   $finish;
endtask
task chk(string s, logic [31:0] g, logic [31:0] e);
   n_checks++;
   if (g !== e) begin mismatches++; $display("ERROR %s exp %h got %h", s, e, g); end
endtask
task bus(logic w, logic [15:0] a, logic [7:0] d);
   int n;
   n = 0;
   read <= !w; write <= w; address <= a; writedata <= {24'h0, d};
   do begin @(posedge core_clk); n++; end while (waitrequest !== 1'b0 && n < 50);
   if (waitrequest !== 1'b0) begin mismatches++; finish_test; end
   rd = readdata;
   read <= 0; write <= 0;
   @(posedge core_clk);
endtask
task rdc(string s, logic [7:0] e); bus(0, 16'hffa6, 8'h0); chk(s, rd, {24'h0, e}); endtask
task wt; repeat (8) @(posedge core_clk); endtask
task ck_irq(logic e); @(negedge core_clk); chk("irq", irq, e); @(posedge core_clk); endtask
task t_reset; rdc("status", 8'h00); bus(0, 16'hffa2, 8'h0); chk("unmapped", rd, 0); endtask
task t_cts;
   lvl.cts <= 1; wt; rdc("cts set", 8'h11);
   bus(1, 16'hffa6, 8'hfe); rdc("w0 keeps", 8'h11);
   bus(1, 16'hffa6, 8'h01); rdc("w1 clears", 8'h10);
   lvl.cts <= 0; wt; bus(1, 16'hffa6, 8'h01);
endtask
task t_ring;
   lvl.ring <= 1; wt; rdc("ring fall", 8'h40);
   lvl.ring <= 0; wt; rdc("ring rise", 8'h04); bus(1, 16'hffa6, 8'h04);
endtask
task t_dc;
   for (int i = 1; i < 4; i += 2) begin
      lvl <= 4'(1 << i); wt; rdc("delta", (8'h10 << i) | (8'h1 << i));
      lvl <= 4'h0; wt; bus(1, 16'hffa6, 8'h0f);
   end
endtask
task t_irq;
   lvl.cts <= 1; wt; ck_irq(0);
   bus(1, 16'hffb0, 8'h0f); ck_irq(1);
   bus(0, 16'hffb0, 8'h0); chk("mask", rd, 32'h0f);
   bus(1, 16'hffa6, 8'h01); ck_irq(0);
   lvl.cts <= 0; wt; bus(1, 16'hffa6, 8'h01);
endtask
task t_loop;
   bus(1, 16'hffa4, 8'h11); bus(0, 16'hffa4, 8'h0); chk("control", rd, 32'h11);
   bus(0, 16'hffa6, 8'h0); chk("loop cts", rd[4], 1);
endtask
initial forever #12.5 core_clk = ~core_clk;
initial begin
   repeat (20) @(posedge core_clk);
   rst <= 0;
   @(posedge core_clk);
   t_reset; t_cts; t_ring; t_dc; t_irq; t_loop;
   finish_test;
end
endmodule

// File: hw/modem_line_status.sv
// Modem line status register with Avalon-MM slave and interrupt
`timescale 1ns/1ps
`include "msr_cfg.svh"
module modem_line_status
   import msr_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   // Modem inputs, active low at the pins
   input  wire modem_lines_t      modem_n,
   // Interrupt
   output logic                   irq
);
   // Register offsets are 16 bits wide, so a narrower bus cannot reach them
   if (ADDR_W < 16) begin : g_addr_check
      $error("ADDR_W must be at least 16");
   end

   modem_lines_t sync1_r, sync2_r, prev_r;
   logic [7:0]   delta_r, control_r, mask_r;
   logic         ack_r;
   logic         wr_status, wr_ctrl, wr_mask;
   logic [3:0]   events;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser; only stage two feeds the edge logic
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_r <= '1;
         sync2_r <= '1;
         prev_r  <= '1;
      end else begin
         sync1_r <= modem_n;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign events[0] = sync2_r.cts ^ prev_r.cts;
   assign events[1] = sync2_r.dsr ^ prev_r.dsr;
   assign events[2] = ~prev_r.ring & sync2_r.ring;
   assign events[3] = sync2_r.carrier ^ prev_r.carrier;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode: one wait cycle, answer on the second edge
   always_ff @(posedge core_clk) begin
      if (rst) ack_r <= 1'b0;
      else     ack_r <= (read | write) & ~ack_r;
   end
   assign waitrequest = (read | write) & ~ack_r;

   assign wr_status = write & ack_r & byteenable[0] && address == `MLS_OFFSET;
   assign wr_ctrl   = write & ack_r & byteenable[0] && address == `MLC_OFFSET;
   assign wr_mask   = write & ack_r & byteenable[0] && address == `IRQ_MASK_OFFSET;

   // Set wins over a same-cycle clear so no transition is lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         delta_r <= `MLS_RESET;
      end else begin
         delta_r[7:4] <= 4'h0;
         delta_r[3:0] <= (delta_r[3:0] & ~(wr_status ? writedata[3:0] : 4'h0))
                         | events;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) control_r <= `MLC_RESET;
      else if (wr_ctrl) control_r <= writedata[7:0];
   end

   always_ff @(posedge core_clk) begin
      if (rst) mask_r <= `MASK_RESET;
      else if (wr_mask) mask_r <= writedata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Level bits are set when the pin is low; loopback shows control bits
   logic loop_en;
   assign loop_en = control_r[`MLC_LOOP_BIT];
   logic [3:0] lvl;
   assign lvl = loop_en ? {control_r[`MLC_CD_BIT], control_r[`MLC_RI_BIT],
                           control_r[`MLC_RTS_BIT], control_r[`MLC_DTR_BIT]}
                        : ~{sync2_r.carrier, sync2_r.ring, sync2_r.dsr, sync2_r.cts};

   always_ff @(posedge core_clk) begin
      if (rst) readdata <= 32'h0000_0000;
      else if (read & ~ack_r) begin
         unique case (address)
            `MLS_OFFSET:      readdata <= {24'h00_0000, lvl, delta_r[3:0]};
            `MLC_OFFSET:      readdata <= {24'h00_0000, control_r};
            `IRQ_MASK_OFFSET: readdata <= {24'h00_0000, mask_r};
            default:          readdata <= 32'h0000_0000;
         endcase
      end
   end

   assign irq = |(delta_r[3:0] & mask_r[3:0]);
   logic unused;
   assign unused = ^{delta_r[7:4], mask_r[7:4], writedata[31:8], byteenable[3:1]};
endmodule

// File: hw/msr_cfg.svh
// Constants for the modem line status register block
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH
`define MLS_OFFSET      16'hffa6
`define MLC_OFFSET      16'hffa4
`define IRQ_MASK_OFFSET 16'hffb0
`define MLS_RESET       8'h00
`define MLC_RESET       8'h00
`define MASK_RESET      8'h00
`define MLC_LOOP_BIT    0
`define MLC_DTR_BIT     4
`define MLC_RTS_BIT     5
`define MLC_RI_BIT      6
`define MLC_CD_BIT      7
`endif

// File: hw/msr_pkg.sv
// Types for the modem line status register block
package msr_pkg;
   typedef struct packed {
      logic carrier;
      logic ring;
      logic dsr;
      logic cts;
   } modem_lines_t;
endpackage
